// ===== src/adcci_pkg.sv
// package: register map, field layout and constants of the converter control
package adcci_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_CLK_CTRL   = 16'hff80;
  localparam logic [15:0] IDX_PIN_SEL    = 16'hff81;
  localparam logic [15:0] IDX_CONV_CTRL  = 16'hff82;
  localparam logic [15:0] IDX_RES_UPPER  = 16'hff83;
  localparam logic [15:0] IDX_RES_LOWER  = 16'hff84;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hff85;
  localparam logic [15:0] IDX_IRQ_CLEAR  = 16'hff86;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'hff87;
  localparam logic [15:0] IDX_IRQ_PRIO   = 16'hff88;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int          POS_GATE      = 3;
  localparam int          POS_DIV_HI    = 2;
  localparam int          POS_PIN_LO    = 4;
  localparam int          POS_START     = 7;
  localparam int          POS_DONE      = 7;
  localparam int          POS_IRQ_EN    = 7;
  localparam int          POS_PRIO_LO   = 6;
  localparam logic [2:0]  RST_DIV       = 3'h0;
  localparam logic        RST_GATE      = 1'h0;
  localparam logic [3:0]  RST_PINS      = 4'h0;
  localparam logic [1:0]  RST_CHANNEL   = 2'h0;
  localparam logic [1:0]  RST_PRIO      = 2'h0;
  localparam logic [2:0]  DIV_SLOW_OSC  = 3'h7;
  localparam int          DIV_TAPS      = 7;
  localparam logic [23:0] IRQ_VECTOR    = 24'h000024;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       start;
    logic [1:0] channel;
    logic       clk_en;
  } adcci_conv_ctl_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } adcci_result_t;

endpackage : adcci_pkg

// ===== src/adcci_prescaler.sv
// prescaler: divided fast-clock enables and synchronised slow-clock edges
`timescale 1ns/10ps
module adcci_prescaler (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_slow_osc_clock,
  input  wire logic [2:0] i_div_select,
  output logic            o_tick
);

  // ----------------------------------------------------------------
  // free running counter and taps
  // ----------------------------------------------------------------
  logic [5:0]                     cnt_reg;
  logic [adcci_pkg::DIV_TAPS-1:0] tap;
  logic [2:0]                     slow_sync_reg;
  logic                           slow_level_reg;
  logic                           slow_edge;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  assign tap[0] = 1'b1;
  genvar g;
  generate
    for (g = 1; g < adcci_pkg::DIV_TAPS; g++) begin : g_tap
      assign tap[g] = &cnt_reg[g-1:0];
    end
  endgenerate

  // ----------------------------------------------------------------
  // slow oscillator pin: three flops, counted once stages agree
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slow_sync_reg  <= 3'h0;
      slow_level_reg <= 1'b0;
    end else begin
      slow_sync_reg <= {slow_sync_reg[1:0], i_slow_osc_clock};
      if (slow_sync_reg[1] == slow_sync_reg[2]) begin
        slow_level_reg <= slow_sync_reg[2];
      end
    end
  end

  assign slow_edge = (slow_sync_reg[1] == slow_sync_reg[2])
                     && slow_sync_reg[2] && !slow_level_reg;

  // select fast tap or slow edge
  always_comb begin
    if (i_div_select == adcci_pkg::DIV_SLOW_OSC) begin
      o_tick = slow_edge;
    end else begin
      o_tick = tap[i_div_select];
    end
  end

endmodule : adcci_prescaler

// ===== src/adcci_top.sv
// top: converter control registers, clock gate and completion interrupt
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
module adcci_top (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_reset_n,
  input  wire logic [17:0]                i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [31:0]                i_avs_writedata,
  input  wire logic [3:0]                 i_avs_byteenable,
  output logic [31:0]                     o_avs_readdata,
  output logic                            o_avs_waitrequest,
  input  wire logic                       i_slow_osc_clock,
  input  wire logic                       i_cpu_mask_level_bit0,
  input  wire logic                       i_cpu_mask_level_bit1,
  input  wire adcci_pkg::adcci_result_t   i_result,
  output adcci_pkg::adcci_conv_ctl_t      o_conv_ctl,
  output logic [3:0]                      o_analog_pin_enable,
  output logic                            o_irq,
  output logic [23:0]                     o_irq_vector
);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        req;
  logic        ack_reg;
  logic        acc;
  logic        wr_acc;
  logic [15:0] idx;
  logic [7:0]  wbyte;
  logic [7:0]  rd_next;
  logic [31:0] readdata_reg;

  logic [2:0]  div_reg;
  logic        gate_reg;
  logic [3:0]  pins_reg;
  logic [1:0]  channel_reg;
  logic        start_reg;
  logic [9:0]  result_reg;
  logic        done_reg;
  logic        irq_en_reg;
  logic [1:0]  prio_reg;
  logic        tick;
  logic [1:0]  mask_level;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction : hit

  assign req    = i_avs_read | i_avs_write;
  assign idx    = i_avs_address[17:2];
  assign acc    = req & ack_reg;
  assign wr_acc = acc & i_avs_write & i_avs_byteenable[0];
  assign wbyte  = i_avs_writedata[7:0];
  assign o_avs_waitrequest = req & !ack_reg;
  assign o_avs_readdata    = readdata_reg;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & !ack_reg;
    end
  end

  always_comb begin
    rd_next = 8'h00;
    case (idx)
      adcci_pkg::IDX_CLK_CTRL:   rd_next = {4'h0, gate_reg, div_reg};
      adcci_pkg::IDX_PIN_SEL:    rd_next = {pins_reg, 4'h0};
      adcci_pkg::IDX_CONV_CTRL:  rd_next = {6'h00, channel_reg};
      adcci_pkg::IDX_RES_UPPER:  rd_next = result_reg[9:2];
      adcci_pkg::IDX_RES_LOWER:  rd_next = {6'h00, result_reg[1:0]};
      adcci_pkg::IDX_IRQ_STATUS: rd_next = {done_reg, 7'h00};
      adcci_pkg::IDX_IRQ_ENABLE: rd_next = {irq_en_reg, 7'h00};
      adcci_pkg::IDX_IRQ_PRIO:   rd_next = {prio_reg, 6'h00};
      default:                   rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      readdata_reg <= 32'h00000000;
    end else if (i_avs_read && !ack_reg) begin
      readdata_reg <= {24'h000000, rd_next};
    end
  end

  // ----------------------------------------------------------------
  // clock control and pin select
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_reg  <= adcci_pkg::RST_DIV;
      gate_reg <= adcci_pkg::RST_GATE;
    end else if (wr_acc && hit(idx, adcci_pkg::IDX_CLK_CTRL)) begin
      div_reg  <= wbyte[adcci_pkg::POS_DIV_HI:0];
      gate_reg <= wbyte[adcci_pkg::POS_GATE];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pins_reg <= adcci_pkg::RST_PINS;
    end else if (wr_acc && hit(idx, adcci_pkg::IDX_PIN_SEL)) begin
      pins_reg <= wbyte[adcci_pkg::POS_PIN_LO +: 4];
    end
  end

  adcci_prescaler u_prescaler (
    .i_clk_sys        (i_clk_sys),
    .i_reset_n        (i_reset_n),
    .i_slow_osc_clock (i_slow_osc_clock),
    .i_div_select     (div_reg),
    .o_tick           (tick)
  );

  // ----------------------------------------------------------------
  // conversion control
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      channel_reg <= adcci_pkg::RST_CHANNEL;
    end else if (wr_acc && hit(idx, adcci_pkg::IDX_CONV_CTRL)) begin
      channel_reg <= wbyte[1:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= wr_acc && hit(idx, adcci_pkg::IDX_CONV_CTRL)
                   && wbyte[adcci_pkg::POS_START];
    end
  end

  // clock is expected running while starting or converting
  assign o_conv_ctl.start   = start_reg;
  assign o_conv_ctl.channel = channel_reg;
  assign o_conv_ctl.clk_en  = gate_reg & tick;
  assign o_analog_pin_enable = pins_reg;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      result_reg <= 10'h000;
    end else if (i_result.valid) begin
      result_reg <= i_result.data;
    end
  end

  // ----------------------------------------------------------------
  // completion flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      done_reg <= 1'b0;
    end else if (i_result.valid) begin
      done_reg <= 1'b1;
    end else if (wr_acc && wbyte[adcci_pkg::POS_DONE]
                 && (hit(idx, adcci_pkg::IDX_IRQ_STATUS)
                     || hit(idx, adcci_pkg::IDX_IRQ_CLEAR))) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_en_reg <= 1'b0;
      prio_reg   <= adcci_pkg::RST_PRIO;
    end else if (wr_acc && hit(idx, adcci_pkg::IDX_IRQ_ENABLE)) begin
      irq_en_reg <= wbyte[adcci_pkg::POS_IRQ_EN];
    end else if (wr_acc && hit(idx, adcci_pkg::IDX_IRQ_PRIO)) begin
      prio_reg <= wbyte[adcci_pkg::POS_PRIO_LO +: 2];
    end
  end

  assign mask_level   = {i_cpu_mask_level_bit1, i_cpu_mask_level_bit0};
  assign o_irq        = done_reg & irq_en_reg
                        & (prio_reg > mask_level);
  assign o_irq_vector = adcci_pkg::IRQ_VECTOR;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  sequence start_write_s;
    wr_acc && idx == adcci_pkg::IDX_CONV_CTRL && wbyte[7];
  endsequence

  sequence clear_write_s;
    wr_acc && idx == adcci_pkg::IDX_IRQ_STATUS && !i_result.valid;
  endsequence

  done_set_a: assert property (i_result.valid |=> done_reg)
    else $error("done flag not set after result");
  result_load_a: assert property (i_result.valid |=>
      result_reg == $past(i_result.data))
    else $error("result not loaded with completion");
  set_unmasked_a: assert property (i_result.valid && !irq_en_reg
      && prio_reg == 2'h0 |=> done_reg)
    else $error("flag depends on enable or priority");
  irq_gate_a: assert property (done_reg && irq_en_reg
      && prio_reg > mask_level |-> o_irq)
    else $error("irq missing");
  irq_block_a: assert property (!irq_en_reg || prio_reg <= mask_level
      |-> !o_irq)
    else $error("irq raised while blocked");
  flag_clear_a: assert property (clear_write_s ##0 wbyte[7]
      |=> !done_reg)
    else $error("write one did not clear flag");
  flag_keep_a: assert property (clear_write_s
      ##0 !wbyte[7] && done_reg |=> done_reg)
    else $error("write zero changed flag");
  vector_fixed_a: assert property (o_irq_vector == 24'h000024)
    else $error("wrong vector");
  gate_off_a: assert property (!gate_reg |-> !o_conv_ctl.clk_en)
    else $error("clock passed while gated");
  div_one_a: assert property (gate_reg && div_reg == 3'h0
      |-> o_conv_ctl.clk_en)
    else $error("undivided clock missing");
  start_pulse_a: assert property (start_write_s |=> o_conv_ctl.start
      ##1 !o_conv_ctl.start)
    else $error("start pulse wrong");
  start_only_a: assert property (o_conv_ctl.start |-> $past(wr_acc))
    else $error("start without write");
  pins_out_a: assert property (wr_acc && idx == adcci_pkg::IDX_PIN_SEL
      |=> o_analog_pin_enable == $past(wbyte[7:4]))
    else $error("pin enables not written");
  chan_out_a: assert property (wr_acc
      && idx == adcci_pkg::IDX_CONV_CTRL
      |=> o_conv_ctl.channel == $past(wbyte[1:0]))
    else $error("channel not written");

  // ----------------------------------------------------------------
  // done flag, register write and readback, and clock checks
  // ----------------------------------------------------------------
  sequence any_clear_s;
    wr_acc && wbyte[7] && (idx == adcci_pkg::IDX_IRQ_STATUS
                           || idx == adcci_pkg::IDX_IRQ_CLEAR);
  endsequence

  sequence read_taken_s;
    i_avs_read && !ack_reg;
  endsequence

  set_wins_a: assert property (any_clear_s ##0 i_result.valid
      |=> done_reg)
    else $error("clear beat a completion");
  flag_sticky_a: assert property (done_reg
      && !(wr_acc && wbyte[7]) |=> done_reg)
    else $error("done flag dropped without clear");
  clear_reg_a: assert property (any_clear_s ##0 !i_result.valid
      |=> !done_reg)
    else $error("clear write did not clear flag");
  irq_flag_a: assert property (!done_reg |-> !o_irq)
    else $error("irq without done flag");
  gate_pass_a: assert property (gate_reg && tick
      |-> o_conv_ctl.clk_en)
    else $error("selected clock blocked");
  div_two_a: assert property (div_reg == 3'h1 && o_conv_ctl.clk_en
      ##1 div_reg == 3'h1 |-> !o_conv_ctl.clk_en)
    else $error("divide by two rate wrong");
  slow_single_a: assert property (div_reg == adcci_pkg::DIV_SLOW_OSC
      && o_conv_ctl.clk_en ##1 div_reg == adcci_pkg::DIV_SLOW_OSC
      |-> !o_conv_ctl.clk_en)
    else $error("slow clock edge passed twice");
  pins_read_a: assert property (read_taken_s
      ##0 idx == adcci_pkg::IDX_PIN_SEL |=> o_avs_readdata[7:0]
      == {$past(pins_reg), 4'h0})
    else $error("pin enables read wrong");
  conv_read_a: assert property (read_taken_s
      ##0 idx == adcci_pkg::IDX_CONV_CTRL |=> o_avs_readdata[7:0]
      == {6'h00, $past(channel_reg)})
    else $error("start bit or channel read wrong");
  upper_read_a: assert property (read_taken_s
      ##0 idx == adcci_pkg::IDX_RES_UPPER |=> o_avs_readdata[7:0]
      == $past(result_reg[9:2]))
    else $error("upper result read wrong");
  lower_read_a: assert property (read_taken_s
      ##0 idx == adcci_pkg::IDX_RES_LOWER |=> o_avs_readdata[7:0]
      == {6'h00, $past(result_reg[1:0])})
    else $error("lower result read wrong");
  start_zero_a: assert property (wr_acc
      && idx == adcci_pkg::IDX_CONV_CTRL && !wbyte[7]
      |=> !o_conv_ctl.start)
    else $error("start without a one written");
  result_hold_a: assert property (!i_result.valid
      |=> $stable(result_reg))
    else $error("result changed without completion");
  chan_hold_a: assert property (!(wr_acc
      && idx == adcci_pkg::IDX_CONV_CTRL) |=> $stable(channel_reg))
    else $error("channel changed without write");
  gate_write_a: assert property (wr_acc
      && idx == adcci_pkg::IDX_CLK_CTRL
      |=> {gate_reg, div_reg} == $past(wbyte[3:0]))
    else $error("clock control not written");

endmodule : adcci_top

// ===== testbench/adcci_conv_model.sv
// converter core model: counts clock enables after a start, returns a result
`timescale 1ns/10ps
module adcci_conv_model (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_reset_n,
  input  wire adcci_pkg::adcci_conv_ctl_t i_conv_ctl,
  input  wire logic [9:0]                 i_data,
  input  wire logic [7:0]                 i_ticks,
  output adcci_pkg::adcci_result_t        o_result
);
  logic       busy_reg;
  logic [7:0] cnt_reg;

  // result data toggles every cycle outside the valid pulse
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_reg <= 1'b0;
      cnt_reg  <= 8'h00;
      o_result <= {1'b0, 10'h155};
    end else begin
      o_result.valid <= 1'b0;
      o_result.data  <= ~o_result.data;
      if (i_conv_ctl.start) begin
        busy_reg <= 1'b1;
        cnt_reg  <= 8'h00;
      end else if (busy_reg && i_conv_ctl.clk_en) begin
        cnt_reg <= cnt_reg + 8'h01;
        if (cnt_reg == i_ticks) begin
          busy_reg <= 1'b0;
          o_result <= {1'b1, i_data};
        end
      end
    end
  end
endmodule : adcci_conv_model

// ===== testbench/adcci_test.sv
// self-checking bench of the converter control block
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module adcci_test;
  logic                       clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic [17:0]                address = 18'h0;
  logic                       read = 1'b0;
  logic                       write = 1'b0;
  logic [31:0]                writedata = 32'h0;
  logic [3:0]                 be = 4'hf;
  logic [31:0]                readdata;
  logic                       waitrequest;
  logic                       slow = 1'b0;
  logic [1:0]                 mask = 2'h0;
  adcci_pkg::adcci_result_t   result;
  adcci_pkg::adcci_conv_ctl_t ctl;
  logic [3:0]                 pins;
  logic                       irq;
  logic [23:0]                vec;
  logic [9:0]                 conv_val = 10'h0;
  logic [7:0]                 ticks = 8'h02;
  logic [7:0]                 rd;
  int                         fails = 0;
  int                         n_compared = 0;
  int                         n_starts = 0;
  int                         n;
  typedef struct {logic [15:0] idx; logic [7:0] wd;
                  logic [7:0] exp;} adcci_row_t;
  adcci_row_t rows[8] = '{
    '{16'hff80, 8'hfe, 8'h0e}, '{16'hff81, 8'h5f, 8'h50},
    '{16'hff82, 8'h7e, 8'h02}, '{16'hff83, 8'hff, 8'h00},
    '{16'hff84, 8'hff, 8'h00}, '{16'hff9f, 8'hff, 8'h00},
    '{16'hff87, 8'h80, 8'h80}, '{16'hff88, 8'h40, 8'h40}};

  always #20 clk = ~clk;
  always @(posedge clk) if (ctl.start === 1'b1) n_starts++;

  adcci_top dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_avs_address(address),
    .i_avs_read(read), .i_avs_write(write), .i_avs_writedata(writedata),
    .i_avs_byteenable(be), .o_avs_readdata(readdata),
    .o_avs_waitrequest(waitrequest), .i_slow_osc_clock(slow),
    .i_cpu_mask_level_bit0(mask[0]), .i_cpu_mask_level_bit1(mask[1]),
    .i_result(result), .o_conv_ctl(ctl), .o_analog_pin_enable(pins),
    .o_irq(irq), .o_irq_vector(vec));
  adcci_conv_model core (.i_clk_sys(clk), .i_reset_n(rst_n),
    .i_conv_ctl(ctl), .i_data(conv_val), .i_ticks(ticks), .o_result(result));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  task automatic bus(input logic wr, input logic [15:0] idx,
                     input logic [7:0] wd);
    int k;
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h0, wd};
    write <= wr;
    read <= !wr;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      fails++;
      complete_run();
    end
    rd = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task automatic check_reset;
    `CHK(vec, 24'h000024)
    `CHK(irq, 1'b0)
    `CHK(pins, 4'h0)
    `CHK(ctl, 4'h0)
    foreach (rows[i]) begin
      bus(1'b0, rows[i].idx, 8'h00);
      `CHK(rd, 8'h00)
    end
  endtask : check_reset

  task automatic count_ticks(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (ctl.clk_en === 1'b1) n++;
    end
  endtask : count_ticks

  task automatic convert(input logic [1:0] ch, input logic [9:0] val);
    int k;
    int s0;
    s0 = n_starts;
    conv_val <= val;
    bus(1'b1, 16'hff82, {6'h20, ch}); // clock gate is on here
    for (k = 0; k < 200; k++) begin
      bus(1'b0, 16'hff85, 8'h00);
      if (rd[7] === 1'b1) break;
    end
    if (k == 200) begin
      fails++;
      complete_run();
    end
    `CHK(rd, 8'h80)
    `CHK(n_starts, s0 + 1)
    `CHK(ctl.channel, ch)
    bus(1'b0, 16'hff83, 8'h00);
    `CHK(rd, val[9:2])
    bus(1'b0, 16'hff84, 8'h00);
    `CHK(rd, {6'h0, val[1:0]})
  endtask : convert

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    check_reset();
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      bus(1'b0, rows[i].idx, 8'h00);
      `CHK(rd, rows[i].exp)
    end
    `CHK(pins, 4'h5)
    `CHK(n_starts, 0)
    be <= 4'he;
    bus(1'b1, 16'hff81, 8'hf0);
    be <= 4'hf;
    bus(1'b0, 16'hff81, 8'h00);
    `CHK(rd, 8'h50)
    for (int c = 0; c < 7; c++) begin
      bus(1'b1, 16'hff80, {5'h01, c[2:0]});
      count_ticks(128);
      `CHK(n, 128 >> c)
    end
    bus(1'b1, 16'hff80, 8'h00);
    count_ticks(32);
    `CHK(n, 0)
    bus(1'b1, 16'hff80, 8'h0f);
    fork
      count_ticks(64);
      repeat (4) begin
        repeat (4) @(posedge clk);
        slow <= 1'b1;
        repeat (4) @(posedge clk);
        slow <= 1'b0;
      end
    join
    `CHK(n, 4)
    bus(1'b1, 16'hff80, 8'h09);
    bus(1'b1, 16'hff87, 8'h00);
    bus(1'b1, 16'hff88, 8'hc0);
    convert(2'h3, 10'h2b5);
    `CHK(irq, 1'b0)
    bus(1'b1, 16'hff87, 8'h80);
    for (int p = 0; p < 4; p++) begin
      bus(1'b1, 16'hff88, {p[1:0], 6'h0});
      for (int m = 0; m < 4; m++) begin
        @(posedge clk);
        mask <= m[1:0];
        @(negedge clk);
        `CHK(irq, p > m)
      end
    end
    bus(1'b1, 16'hff85, 8'h00);
    bus(1'b0, 16'hff85, 8'h00);
    `CHK(rd, 8'h80)
    bus(1'b1, 16'hff85, 8'h80);
    bus(1'b0, 16'hff85, 8'h00);
    `CHK(rd, 8'h00)
    `CHK(irq, 1'b0)
    ticks <= 8'h14;
    bus(1'b1, 16'hff80, 8'h0a);
    convert(2'h0, 10'h0ca);
    bus(1'b1, 16'hff86, 8'h80);
    bus(1'b0, 16'hff85, 8'h00);
    `CHK(rd, 8'h00)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    check_reset();
    complete_run();
  end
endmodule : adcci_test
